// file: rps_pkg.sv
`default_nettype none
package rps_pkg;

  // Register port geometry.
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // Register indices on the plain register port.
  localparam logic [ADDR_W-1:0] REG_FAULT_MAP = 4'h0;
  localparam logic [ADDR_W-1:0] REG_OUT_MAP0 = 4'h1;
  localparam logic [ADDR_W-1:0] REG_OUT_MAP1 = 4'h2;

  // Field layouts.
  localparam int FAULT_SEL_W = 7;
  localparam int FAULT_SEL_LSB = 0;
  localparam int OUT_SEL_W = 6;
  localparam int OUT_HI_LSB = 8;
  localparam int OUT_LO_LSB = 0;

  // Reset values.
  localparam logic [FAULT_SEL_W-1:0] FAULT_SEL_RST = 7'h00;
  localparam logic [OUT_SEL_W-1:0] OUT_SEL_RST = 6'h00;
  localparam logic [DATA_W-1:0] RDATA_IDLE = 16'h0000;

  // Input select codes.
  localparam logic [FAULT_SEL_W-1:0] SEL_GROUND = 7'h00;
  localparam logic [FAULT_SEL_W-1:0] SEL_COMPARATOR_ONE = 7'h01;
  localparam logic [FAULT_SEL_W-1:0] SEL_REMAP_PIN_121 = 7'h79;
  localparam int SRC_NUM = 128;
  localparam int SRC_FIRST_PIN = 2;
  localparam int PIN_NUM = SRC_NUM - SRC_FIRST_PIN;

  // Output function codes; code zero means no peripheral function.
  localparam int FUNC_NUM = 64;
  localparam logic [OUT_SEL_W-1:0] FUNC_NONE = 6'h00;
  localparam logic [FUNC_NUM-1:0] FUNC_IMPL_MASK = 64'hffff_ffff_ffff_fffe;

  // Remappable output pin slots.
  localparam int OUT_PINS = 4;
  localparam int SLOT_PIN20 = 0;
  localparam int SLOT_PIN35 = 1;
  localparam int SLOT_PIN36 = 2;
  localparam int SLOT_PIN37 = 3;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } rps_bus_req_type;

  typedef struct packed {
    logic en;
    logic val;
  } rps_pin_drive_type;

endpackage
`default_nettype wire

// file: rps_sync.sv
`timescale 1ns/1ps
`default_nettype none
module rps_sync
  import rps_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Asynchronous levels in, synchronised levels out.
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stage1_r <= '0;
      sync_out <= '0;
    end else begin
      stage1_r <= async_in;
      sync_out <= stage1_r;
    end
  end

endmodule
`default_nettype wire

// file: rps_pin_select.sv
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [RULE1] The fault input map holds a writable 7-bit select in its low bits that picks the fault A source.
// [RULE2] Select zero grounds the fault A input, select one passes comparator one, and 0x79 passes pin 121.
// [RULE3] Unimplemented bits of all three map registers read as zero and ignore writes.
// [RULE4] Output map zero holds the pin 35 select in bits 13 to 8 and the pin 20 select in bits 5 to 0.
// [RULE5] Output map one holds the pin 37 select in bits 13 to 8 and the pin 36 select in bits 5 to 0.
// [RULE6] Every select field is readable, writable and clears to zero at reset.
// [RULE7] An output select of zero or of an undefined code leaves its pin under ordinary port control.
module rps_pin_select
  import rps_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Register port.
  input wire rps_bus_req_type bus_req,
  output logic [DATA_W-1:0] bus_rdata,
  // Fault A input sources.
  input wire logic comparator_one_output,
  input wire logic [SRC_NUM-1:SRC_FIRST_PIN] remap_in_pins,
  output logic compare_fault_a_input,
  // Peripheral output functions and remapped pin drive.
  input wire logic [FUNC_NUM-1:0] periph_func_out,
  output logic [OUT_PINS-1:0] pin_remap_en,
  output logic [OUT_PINS-1:0] pin_remap_out
);

  logic [FAULT_SEL_W-1:0] fault_a_input_select_r;
  logic [OUT_PINS-1:0][OUT_SEL_W-1:0] out_sel_r;
  logic [PIN_NUM-1:0] pins_sync;
  logic [SRC_NUM-1:0] src_vec;
  logic fault_nxt;
  logic [DATA_W-1:0] rdata_nxt;
  rps_pin_drive_type [OUT_PINS-1:0] drive_nxt;

  // Undefined codes map to no function so a stray write cannot grab a pin.
  function automatic rps_pin_drive_type pin_drive(input logic [OUT_SEL_W-1:0] sel,
                                                   input logic [FUNC_NUM-1:0] funcs);
    rps_pin_drive_type d;
    d.en = FUNC_IMPL_MASK[sel] && (sel != FUNC_NONE);
    d.val = d.en & funcs[sel];
    return d;
  endfunction

  function automatic logic [DATA_W-1:0] pack_pair(input logic [OUT_SEL_W-1:0] hi,
                                                  input logic [OUT_SEL_W-1:0] lo);
    logic [DATA_W-1:0] w;
    w = '0;
    w[OUT_HI_LSB +: OUT_SEL_W] = hi;
    w[OUT_LO_LSB +: OUT_SEL_W] = lo;
    return w;
  endfunction

  rps_sync #(
    .WIDTH(PIN_NUM)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .async_in(remap_in_pins),
    .sync_out(pins_sync)
  );

  // Fault select register; only the low seven bits are stored.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fault_a_input_select_r <= FAULT_SEL_RST; // [RULE6]
    end else if (bus_req.wr && bus_req.addr == REG_FAULT_MAP) begin
      fault_a_input_select_r <= bus_req.wdata[FAULT_SEL_LSB +: FAULT_SEL_W]; // [RULE1]
    end
  end

  // Output select registers; bits 15-14 and 7-6 are dropped on write.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      out_sel_r <= {OUT_PINS{OUT_SEL_RST}}; // [RULE6]
    end else if (bus_req.wr && bus_req.addr == REG_OUT_MAP0) begin
      out_sel_r[SLOT_PIN35] <= bus_req.wdata[OUT_HI_LSB +: OUT_SEL_W]; // [RULE4]
      out_sel_r[SLOT_PIN20] <= bus_req.wdata[OUT_LO_LSB +: OUT_SEL_W]; // [RULE4]
    end else if (bus_req.wr && bus_req.addr == REG_OUT_MAP1) begin
      out_sel_r[SLOT_PIN37] <= bus_req.wdata[OUT_HI_LSB +: OUT_SEL_W]; // [RULE5]
      out_sel_r[SLOT_PIN36] <= bus_req.wdata[OUT_LO_LSB +: OUT_SEL_W]; // [RULE5]
    end
  end

  // Read data, zero outside the single cycle after a read strobe.
  always_comb begin
    rdata_nxt = RDATA_IDLE;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        REG_FAULT_MAP: rdata_nxt[FAULT_SEL_LSB +: FAULT_SEL_W] = fault_a_input_select_r; // [RULE3]
        REG_OUT_MAP0: begin
          rdata_nxt = pack_pair(out_sel_r[SLOT_PIN35], out_sel_r[SLOT_PIN20]); // [RULE3]
        end
        REG_OUT_MAP1: begin
          rdata_nxt = pack_pair(out_sel_r[SLOT_PIN37], out_sel_r[SLOT_PIN36]); // [RULE3]
        end
        default: rdata_nxt = RDATA_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bus_rdata <= RDATA_IDLE;
    end else begin
      bus_rdata <= rdata_nxt;
    end
  end

  // Source vector indexed by select code: ground, comparator one, then pins.
  always_comb begin
    src_vec = '0;
    src_vec[SEL_COMPARATOR_ONE] = comparator_one_output; // [RULE2]
    src_vec[SRC_NUM-1:SRC_FIRST_PIN] = pins_sync; // [RULE2]
    fault_nxt = src_vec[fault_a_input_select_r]; // [RULE2]
  end

  // Registering the mux output costs a cycle but keeps the fault input glitch free.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      compare_fault_a_input <= 1'b0;
    end else begin
      compare_fault_a_input <= fault_nxt;
    end
  end

  // Drive decode for all four slots, registered below.
  always_comb begin
    for (int i = 0; i < OUT_PINS; i++) begin
      drive_nxt[i] = pin_drive(out_sel_r[i], periph_func_out); // [RULE7]
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_remap_en <= '0;
      pin_remap_out <= '0;
    end else begin
      for (int i = 0; i < OUT_PINS; i++) begin
        pin_remap_en[i] <= drive_nxt[i].en; // [RULE7]
        pin_remap_out[i] <= drive_nxt[i].val; // [RULE7]
      end
    end
  end

  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  AST_FAULT_WRITE: assert property ( // [RULE1]
    bus_req.wr && bus_req.addr == REG_FAULT_MAP
    |=> fault_a_input_select_r == $past(bus_req.wdata[FAULT_SEL_W-1:0]))
    else $error("Fault select did not take the written value.");

  AST_FAULT_GROUND: assert property ( // [RULE2]
    fault_a_input_select_r == SEL_GROUND |=> !compare_fault_a_input)
    else $error("Fault input not grounded on select zero.");

  AST_FAULT_CMP: assert property ( // [RULE2]
    fault_a_input_select_r == SEL_COMPARATOR_ONE
    |=> compare_fault_a_input == $past(comparator_one_output))
    else $error("Fault input does not follow comparator one.");

  AST_FAULT_PIN121: assert property ( // [RULE2]
    fault_a_input_select_r == SEL_REMAP_PIN_121
    |=> compare_fault_a_input == $past(pins_sync[SEL_REMAP_PIN_121 - SRC_FIRST_PIN]))
    else $error("Fault input does not follow pin 121.");

  AST_FAULT_RSVD: assert property ( // [RULE3]
    bus_req.rd && bus_req.addr == REG_FAULT_MAP |=> bus_rdata[DATA_W-1:FAULT_SEL_W] == '0)
    else $error("Unimplemented fault map bits read nonzero.");

  AST_OUT0_WRITE: assert property ( // [RULE4]
    bus_req.wr && bus_req.addr == REG_OUT_MAP0
    |=> out_sel_r[SLOT_PIN35] == $past(bus_req.wdata[13:8])
        && out_sel_r[SLOT_PIN20] == $past(bus_req.wdata[5:0]))
    else $error("Output map zero fields misplaced.");

  AST_OUT1_WRITE: assert property ( // [RULE5]
    bus_req.wr && bus_req.addr == REG_OUT_MAP1
    |=> out_sel_r[SLOT_PIN37] == $past(bus_req.wdata[13:8])
        && out_sel_r[SLOT_PIN36] == $past(bus_req.wdata[5:0]))
    else $error("Output map one fields misplaced.");

  AST_OUT1_READ: assert property ( // [RULE6]
    bus_req.rd && bus_req.addr == REG_OUT_MAP1
    |=> bus_rdata == {2'h0, $past(out_sel_r[SLOT_PIN37]), 2'h0, $past(out_sel_r[SLOT_PIN36])})
    else $error("Output map one readback wrong.");

  AST_ZERO_SEL: assert property ( // [RULE7]
    out_sel_r[SLOT_PIN20] == FUNC_NONE |=> !pin_remap_en[SLOT_PIN20] && !pin_remap_out[SLOT_PIN20])
    else $error("Pin 20 driven with select zero.");

  AST_FAULT_READ: assert property ( // [RULE1]
    bus_req.rd && bus_req.addr == REG_FAULT_MAP
    |=> bus_rdata == {9'h000, $past(fault_a_input_select_r)})
    else $error("Fault map readback wrong.");

  AST_OUT0_READ: assert property ( // [RULE4]
    bus_req.rd && bus_req.addr == REG_OUT_MAP0
    |=> bus_rdata == {2'h0, $past(out_sel_r[SLOT_PIN35]), 2'h0, $past(out_sel_r[SLOT_PIN20])})
    else $error("Output map zero readback wrong.");

  AST_UNMAPPED_READ: assert property ( // [RULE3]
    bus_req.rd && bus_req.addr > REG_OUT_MAP1 |=> bus_rdata == RDATA_IDLE)
    else $error("Unmapped register read nonzero.");

  AST_UNMAPPED_WRITE: assert property ( // [RULE3]
    bus_req.wr && bus_req.addr > REG_OUT_MAP1
    |=> $stable(out_sel_r) && $stable(fault_a_input_select_r))
    else $error("Unmapped register write changed a select.");

  AST_PIN35_FOLLOW: assert property ( // [RULE4]
    out_sel_r[SLOT_PIN35] != FUNC_NONE && FUNC_IMPL_MASK[out_sel_r[SLOT_PIN35]]
    |=> pin_remap_en[SLOT_PIN35]
        && pin_remap_out[SLOT_PIN35] == $past(periph_func_out[out_sel_r[SLOT_PIN35]]))
    else $error("Pin 35 does not follow its selected function.");

  AST_PIN36_FOLLOW: assert property ( // [RULE5]
    out_sel_r[SLOT_PIN36] != FUNC_NONE && FUNC_IMPL_MASK[out_sel_r[SLOT_PIN36]]
    |=> pin_remap_en[SLOT_PIN36]
        && pin_remap_out[SLOT_PIN36] == $past(periph_func_out[out_sel_r[SLOT_PIN36]]))
    else $error("Pin 36 does not follow its selected function.");

  AST_PIN37_FOLLOW: assert property ( // [RULE5]
    out_sel_r[SLOT_PIN37] != FUNC_NONE && FUNC_IMPL_MASK[out_sel_r[SLOT_PIN37]]
    |=> pin_remap_en[SLOT_PIN37]
        && pin_remap_out[SLOT_PIN37] == $past(periph_func_out[out_sel_r[SLOT_PIN37]]))
    else $error("Pin 37 does not follow its selected function.");

endmodule
`default_nettype wire

// file: rps_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module rps_far_model
  import rps_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Levels requested by the bench.
  input wire logic comp_lvl,
  input wire logic [SRC_NUM-1:SRC_FIRST_PIN] pin_lvl,
  input wire logic [FUNC_NUM-1:0] func_lvl,
  // Levels seen by the remap unit.
  output logic comp_out,
  output wire logic [SRC_NUM-1:SRC_FIRST_PIN] pin_out,
  output logic [FUNC_NUM-1:0] func_out
);
  // Peripherals launch on the system clock and clear asynchronously when nrst falls.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      comp_out <= 1'b0;
      func_out <= '0;
    end else begin
      comp_out <= comp_lvl;
      func_out <= func_lvl;
    end
  end
  // Pins are outside the clock domain, so they move at an awkward phase.
  assign #23 pin_out = pin_lvl;
endmodule
`default_nettype wire

// file: test_rps_pin_select.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module test_rps_pin_select
  import rps_pkg::*;
;
  localparam logic [FAULT_SEL_W-1:0] CODES [3] =
    '{SEL_GROUND, SEL_COMPARATOR_ONE, SEL_REMAP_PIN_121};
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  rps_bus_req_type bus_req = '0;
  logic [DATA_W-1:0] bus_rdata;
  logic cmp_lvl = 1'b0;
  logic [SRC_NUM-1:SRC_FIRST_PIN] pin_lvl = '0;
  logic [FUNC_NUM-1:0] func_lvl = '0;
  logic cmp_q;
  wire logic [SRC_NUM-1:SRC_FIRST_PIN] pin_q;
  logic [FUNC_NUM-1:0] func_q;
  logic fault_a;
  logic [OUT_PINS-1:0] pin_en;
  logic [OUT_PINS-1:0] pin_out;
  logic [DATA_W-1:0] exp_q [$];
  logic [DATA_W-1:0] e_now;
  logic e_bit;
  logic rd_seen = 1'b0;
  logic [OUT_SEL_W-1:0] sel [OUT_PINS];
  int failures = 0;
  int checked = 0;
  always #50 clk_sys = ~clk_sys;
  rps_far_model i_far (.clk_sys(clk_sys), .nrst(nrst), .comp_lvl(cmp_lvl), .pin_lvl(pin_lvl),
    .func_lvl(func_lvl), .comp_out(cmp_q), .pin_out(pin_q), .func_out(func_q));
  rps_pin_select i_dut (.clk_sys(clk_sys), .nrst(nrst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .comparator_one_output(cmp_q), .remap_in_pins(pin_q), .compare_fault_a_input(fault_a),
    .periph_func_out(func_q), .pin_remap_en(pin_en), .pin_remap_out(pin_out));
  task automatic put(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic w,
                     input logic r);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: r};
  endtask
  task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    exp_q.push_back(e);
    put(a, '0, 1'b0, 1'b1);
  endtask
  task automatic settle;
    put('0, '0, 1'b0, 1'b0);
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic finish_test;
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Read data belong to the cycle after the strobe and are zero otherwise.
  // Sampling on the falling edge keeps the check clear of the edge that launches the data.
  always @(negedge clk_sys) begin
    e_now = rd_seen ? exp_q.pop_front() : RDATA_IDLE;
    `CHK("read data", e_now, bus_rdata)
    rd_seen = bus_req.rd;
  end
  initial begin
    void'($urandom(32'hc07d));
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    rd_reg(REG_FAULT_MAP, 16'h0000);
    rd_reg(REG_OUT_MAP0, 16'h0000);
    rd_reg(REG_OUT_MAP1, 16'h0000);
    @(negedge clk_sys);
    `CHK("reset fault", 1'b0, fault_a)
    put(REG_FAULT_MAP, 16'hffff, 1'b1, 1'b0);
    rd_reg(REG_FAULT_MAP, 16'h007f);
    put(REG_OUT_MAP0, 16'hffff, 1'b1, 1'b0);
    put(REG_OUT_MAP1, 16'hc0c0, 1'b1, 1'b0);
    put(4'h3, 16'hffff, 1'b1, 1'b0);
    rd_reg(REG_OUT_MAP0, 16'h3f3f);
    rd_reg(REG_OUT_MAP1, 16'h0000);
    rd_reg(4'h3, 16'h0000);
    for (int i = 0; i < 12; i++) begin
      put(REG_FAULT_MAP, {9'h000, CODES[i%3]}, 1'b1, 1'b0);
      cmp_lvl <= 1'($urandom);
      pin_lvl <= PIN_NUM'({$urandom, $urandom, $urandom, $urandom});
      settle();
      e_bit = (i % 3 == 0) ? 1'b0 : (i % 3 == 1) ? cmp_lvl : pin_lvl[SEL_REMAP_PIN_121];
      `CHK("fault a", e_bit, fault_a)
    end
    for (int k = 0; k < 8; k++) begin
      foreach (sel[j]) sel[j] = (k == 0) ? '0 : OUT_SEL_W'($urandom_range(63, 0));
      put(REG_OUT_MAP0, {2'b00, sel[1], 2'b00, sel[0]}, 1'b1, 1'b0);
      put(REG_OUT_MAP1, {2'b00, sel[3], 2'b00, sel[2]}, 1'b1, 1'b0);
      func_lvl <= {$urandom, $urandom};
      rd_reg(REG_OUT_MAP1, {2'b00, sel[3], 2'b00, sel[2]});
      settle();
      foreach (sel[j]) begin
        `CHK("pin enable", sel[j] != '0, pin_en[j])
        `CHK("pin value", (sel[j] != '0) && func_lvl[sel[j]], pin_out[j])
      end
    end
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK("enables in reset", 4'h0, pin_en)
    nrst <= 1'b1;
    rd_reg(REG_OUT_MAP0, 16'h0000);
    settle();
    `CHK("reads left", 0, exp_q.size())
    finish_test();
  end
  initial begin
    #500000;
    failures++;
    finish_test();
  end
endmodule
`default_nettype wire
